// [core/mdc_copy_channel.sv]
`timescale 1ns/1ns
// Functional notes
// - fetch descriptor at pointer before data
// - start at software loaded descriptor pointer
// - read element, write it, advance both, source only for scatter
// - repeat until count plus one elements
// - type three is memory copy
// - select one interrupts after each inner loop
// - wait bit zero skips trigger release
// - software trigger accepted as channel request
// - chain to next link, zero ends
// - single descriptor moves one sized element
// - one loop or nested two loops
// - crc type unsupported here, flagged error
// - scatter writes words to listed addresses
module mdc_copy_channel
   import mdc_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // trigger from the multiplexer
   input wire logic i_trig_in,
   // memory master port
   output logic o_mem_req,
   output logic o_mem_we,
   output logic [31:0] o_mem_addr,
   output logic [1:0] o_mem_size,
   output logic [31:0] o_mem_wdata,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata,
   // channel events
   output logic o_irq,
   output logic o_trig_out
);
   // ************************************************************
   // declarations
   // ************************************************************
   mdc_state_t state_r, state_nxt; // sequencer
   logic ctrl_en_r, ctrl_en_nxt; // controller_enable
   logic ch_en_r, ch_en_nxt; // channel_enable
   logic [1:0] prio_r, prio_nxt; // channel_priority, read back only
   logic [31:0] ptr_r, ptr_nxt; // channel_current_descriptor_pointer
   logic swt_r, swt_nxt; // software trigger pulse
   logic done_r, done_nxt; // sticky descriptor done
   logic err_r, err_nxt; // sticky bad descriptor type
   logic chain_r, chain_nxt; // chained descriptor pending
   logic [2:0] idx_r, idx_nxt; // descriptor word being fetched
   logic [31:0] ctl_r, ctl_nxt; // control word
   logic [31:0] src_r, src_nxt; // source_address_word, advancing
   logic [31:0] dst_r, dst_nxt; // destination_address_word, advancing
   logic [31:0] loop_r, loop_nxt; // copy_loop_control_word
   logic [31:0] next_r, next_nxt; // next_descriptor_link
   logic [31:0] scat_r, scat_nxt; // scatter target address
   logic [15:0] cnt_r, cnt_nxt; // inner elements left minus one
   logic [15:0] ycnt_r, ycnt_nxt; // outer rows left minus one
   logic [1:0] size_r, size_nxt; // element size code in use
   logic [31:0] prdata_r, prdata_nxt; // registered read data
   logic slverr_r, slverr_nxt; // registered error answer
   logic irq_r, irq_nxt; // interrupt pulse
   logic tro_r, tro_nxt; // output trigger pulse
   logic setup_ph; // apb setup phase
   logic wr_acc; // apb write access phase
   logic start; // trigger accepted
   logic [2:0] dtype; // descriptor_operation_type
   logic [1:0] irq_sel; // interrupt_select
   logic [1:0] tro_sel; // output_trigger_select
   logic is_scat; // scatter descriptor running
   logic [31:0] step; // bytes per element
   logic [31:0] status_w; // status word image
   logic buf_in_ready; // buffer can take a word
   logic buf_out_valid; // buffer holds a word
   logic [31:0] buf_data; // oldest buffered word
   logic rd_push; // read data into buffer
   logic wr_pop; // write accepted from buffer

   // ************************************************************
   // decode helpers
   // ************************************************************
   assign setup_ph = i_psel && !i_penable;
   assign wr_acc = i_psel && i_penable && i_pwrite;
   assign dtype = ctl_r[MDC_DC_TYPE_LSB +: 3];
   assign irq_sel = ctl_r[MDC_DC_IRQ_LSB +: 2];
   assign tro_sel = ctl_r[MDC_DC_TRO_LSB +: 2];
   assign is_scat = (dtype == MDC_TYPE_SCATTER);
   assign step = MDC_ONE << size_r;
   // gate every trigger on both enables
   assign start = ctrl_en_r && ch_en_r && (i_trig_in || swt_r || chain_r);

   // status image, reserved bits zero
   always_comb begin
      status_w = '0;
      // a pending chain counts as busy, so polling never sees a gap between links
      status_w[MDC_ST_BUSY_BIT] = (state_r != MDC_IDLE) || chain_r;
      status_w[MDC_ST_DONE_BIT] = done_r;
      status_w[MDC_ST_ERR_BIT] = err_r;
      status_w[MDC_ST_STATE_LSB +: 3] = state_r;
   end

   // ************************************************************
   // memory port, combinational handshake
   // ************************************************************
   // read only when the buffer has room, so a stalled write loses nothing
   assign rd_push = (state_r == MDC_READ) && buf_in_ready && i_mem_ack;
   assign wr_pop = (state_r == MDC_WRITE) && buf_out_valid && i_mem_ack;
   assign o_mem_we = (state_r == MDC_WRITE);
   assign o_mem_wdata = buf_data;

   always_comb begin
      o_mem_req = 1'b0;
      o_mem_addr = src_r;
      o_mem_size = size_r;
      case (state_r)
         MDC_FETCH: begin
            o_mem_req = 1'b1;
            o_mem_addr = ptr_r + MDC_WORD_BYTES * 32'(idx_r);
            o_mem_size = MDC_SIZE_32;
         end
         // target address word of a pair
         MDC_SCAT_ADDR: begin
            o_mem_req = 1'b1;
            o_mem_size = MDC_SIZE_32;
         end
         MDC_READ: begin
            o_mem_req = buf_in_ready;
            o_mem_addr = is_scat ? src_r + MDC_WORD_BYTES : src_r;
         end
         MDC_WRITE: begin
            o_mem_req = buf_out_valid;
            o_mem_addr = is_scat ? scat_r : dst_r;
         end
         default: begin
            o_mem_req = 1'b0;
         end
      endcase
   end

   // element buffer in the data path
   mdc_pair_buffer #(
      .WIDTH(32),
      .DEPTH(2)
   ) u_buf (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_in_valid(rd_push),
      .o_in_ready(buf_in_ready),
      .i_in_data(i_mem_rdata),
      .o_out_valid(buf_out_valid),
      .i_out_ready(wr_pop),
      .o_out_data(buf_data)
   );

   // ************************************************************
   // next state: registers and sequencer
   // ************************************************************
   always_comb begin
      state_nxt = state_r;
      ctrl_en_nxt = ctrl_en_r;
      ch_en_nxt = ch_en_r;
      prio_nxt = prio_r;
      ptr_nxt = ptr_r;
      swt_nxt = 1'b0;
      done_nxt = done_r;
      err_nxt = err_r;
      chain_nxt = chain_r;
      idx_nxt = idx_r;
      ctl_nxt = ctl_r;
      src_nxt = src_r;
      dst_nxt = dst_r;
      loop_nxt = loop_r;
      next_nxt = next_r;
      scat_nxt = scat_r;
      cnt_nxt = cnt_r;
      ycnt_nxt = ycnt_r;
      size_nxt = size_r;
      prdata_nxt = prdata_r;
      slverr_nxt = slverr_r;
      irq_nxt = 1'b0;
      tro_nxt = 1'b0;
      // read data and error captured in setup, valid in access
      if (setup_ph) begin
         slverr_nxt = 1'b0;
         prdata_nxt = '0;
         case (i_paddr)
            MDC_OFS_CTRL: prdata_nxt[MDC_CTRL_EN_BIT] = ctrl_en_r;
            MDC_OFS_CH_CTL: begin
               prdata_nxt[MDC_CH_EN_BIT] = ch_en_r;
               prdata_nxt[MDC_CH_PRIO_LSB +: 2] = prio_r;
            end
            MDC_OFS_CURR_PTR: prdata_nxt = ptr_r;
            MDC_OFS_SW_TRIG: prdata_nxt = '0;
            MDC_OFS_STATUS: prdata_nxt = status_w;
            MDC_OFS_SRC: prdata_nxt = src_r;
            MDC_OFS_DST: prdata_nxt = dst_r;
            default: slverr_nxt = 1'b1;
         endcase
      end
      // writes take effect in the access phase
      if (wr_acc) begin
         case (i_paddr)
            MDC_OFS_CTRL: ctrl_en_nxt = i_pwdata[MDC_CTRL_EN_BIT];
            MDC_OFS_CH_CTL: begin
               ch_en_nxt = i_pwdata[MDC_CH_EN_BIT];
               prio_nxt = i_pwdata[MDC_CH_PRIO_LSB +: 2];
            end
            MDC_OFS_CURR_PTR: ptr_nxt = i_pwdata;
            MDC_OFS_SW_TRIG: swt_nxt = i_pwdata[MDC_SWT_BIT];
            MDC_OFS_STATUS: begin
               if (i_pwdata[MDC_ST_DONE_BIT]) begin
                  done_nxt = 1'b0;
               end
               if (i_pwdata[MDC_ST_ERR_BIT]) begin
                  err_nxt = 1'b0;
               end
            end
            default: begin
               ctrl_en_nxt = ctrl_en_r;
            end
         endcase
      end
      // sequencer; its flag sets come after the clears so a set wins
      case (state_r)
         MDC_IDLE: begin
            // line and software triggers without both enables are dropped; a pending chain is held
            if (start) begin
               state_nxt = MDC_FETCH;
               idx_nxt = MDC_DW_CTL;
               chain_nxt = 1'b0;
            end
         end
         // whole descriptor read before any data moves
         MDC_FETCH: begin
            if (i_mem_ack) begin
               idx_nxt = idx_r + 1'b1;
               case (idx_r)
                  MDC_DW_CTL: ctl_nxt = i_mem_rdata;
                  MDC_DW_SRC: src_nxt = i_mem_rdata;
                  MDC_DW_DST: dst_nxt = i_mem_rdata;
                  MDC_DW_LOOP: loop_nxt = i_mem_rdata;
                  default: next_nxt = i_mem_rdata;
               endcase
               if (idx_r == MDC_DW_NEXT) begin
                  cnt_nxt = loop_r[MDC_LC_X_LSB +: 16];
                  ycnt_nxt = '0;
                  size_nxt = ctl_r[MDC_DC_SIZE_LSB +: 2];
                  state_nxt = MDC_READ;
                  case (dtype)
                     MDC_TYPE_SINGLE: cnt_nxt = '0;
                     MDC_TYPE_ONE_D, MDC_TYPE_MEMCPY: cnt_nxt = loop_r[MDC_LC_X_LSB +: 16];
                     MDC_TYPE_TWO_D: ycnt_nxt = loop_r[MDC_LC_Y_LSB +: 16];
                     MDC_TYPE_SCATTER: begin
                        size_nxt = MDC_SIZE_32;
                        state_nxt = MDC_SCAT_ADDR;
                     end
                     // crc belongs to the peripheral engine; stop, flag it
                     default: begin
                        err_nxt = 1'b1;
                        done_nxt = 1'b1;
                        ch_en_nxt = 1'b0;
                        state_nxt = MDC_IDLE;
                     end
                  endcase
                  if (size_nxt > MDC_SIZE_32) begin
                     size_nxt = MDC_SIZE_32;
                  end
               end
            end
         end
         MDC_SCAT_ADDR: begin
            if (i_mem_ack) begin
               scat_nxt = i_mem_rdata;
               state_nxt = MDC_READ;
            end
         end
         MDC_READ: begin
            if (rd_push) begin
               state_nxt = MDC_WRITE;
            end
         end
         MDC_WRITE: begin
            if (wr_pop) begin
               src_nxt = src_r + (is_scat ? MDC_PAIR_BYTES : step);
               dst_nxt = is_scat ? dst_r : dst_r + step;
               irq_nxt = (irq_sel == MDC_EV_ELEM);
               tro_nxt = (tro_sel == MDC_EV_ELEM);
               state_nxt = is_scat ? MDC_SCAT_ADDR : MDC_READ;
               if (cnt_r != '0) begin
                  cnt_nxt = cnt_r - 1'b1;
               end else begin
                  irq_nxt = irq_nxt || (irq_sel == MDC_EV_XLOOP);
                  tro_nxt = tro_nxt || (tro_sel == MDC_EV_XLOOP);
                  // outer loop restarts the inner one
                  if (ycnt_r != '0) begin
                     ycnt_nxt = ycnt_r - 1'b1;
                     cnt_nxt = loop_r[MDC_LC_X_LSB +: 16];
                  end else begin
                     state_nxt = MDC_FINISH;
                  end
               end
            end
         end
         // follow the link; a null link ends the chain
         MDC_FINISH: begin
            ptr_nxt = next_r;
            done_nxt = 1'b1;
            irq_nxt = (irq_sel == MDC_EV_DESCR);
            tro_nxt = (tro_sel == MDC_EV_DESCR);
            if ((next_r == MDC_NULL_PTR) || ctl_r[MDC_DC_STOP_BIT]) begin
               ch_en_nxt = 1'b0;
               irq_nxt = irq_nxt || (irq_sel == MDC_EV_CHAIN);
               tro_nxt = tro_nxt || (tro_sel == MDC_EV_CHAIN);
            end else begin
               chain_nxt = 1'b1;
            end
            // no wait unless the bit asks for it
            state_nxt = ctl_r[MDC_DC_WAIT_BIT] ? MDC_WAIT_REL : MDC_IDLE;
         end
         MDC_WAIT_REL: begin
            if (!i_trig_in) begin
               state_nxt = MDC_IDLE;
            end
         end
         default: begin
            state_nxt = MDC_IDLE;
         end
      endcase
   end

   // ************************************************************
   // state registers
   // ************************************************************
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= MDC_IDLE;
         ctrl_en_r <= 1'b0;
         ch_en_r <= 1'b0;
         prio_r <= '0;
         ptr_r <= '0;
         swt_r <= 1'b0;
         done_r <= 1'b0;
         err_r <= 1'b0;
         chain_r <= 1'b0;
         idx_r <= '0;
         ctl_r <= '0;
         src_r <= '0;
         dst_r <= '0;
         loop_r <= '0;
         next_r <= '0;
         scat_r <= '0;
         cnt_r <= '0;
         ycnt_r <= '0;
         size_r <= '0;
         prdata_r <= '0;
         slverr_r <= 1'b0;
         irq_r <= 1'b0;
         tro_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ctrl_en_r <= ctrl_en_nxt;
         ch_en_r <= ch_en_nxt;
         prio_r <= prio_nxt;
         ptr_r <= ptr_nxt;
         swt_r <= swt_nxt;
         done_r <= done_nxt;
         err_r <= err_nxt;
         chain_r <= chain_nxt;
         idx_r <= idx_nxt;
         ctl_r <= ctl_nxt;
         src_r <= src_nxt;
         dst_r <= dst_nxt;
         loop_r <= loop_nxt;
         next_r <= next_nxt;
         scat_r <= scat_nxt;
         cnt_r <= cnt_nxt;
         ycnt_r <= ycnt_nxt;
         size_r <= size_nxt;
         prdata_r <= prdata_nxt;
         slverr_r <= slverr_nxt;
         irq_r <= irq_nxt;
         tro_r <= tro_nxt;
      end
   end

   // outputs; apb never waits
   assign o_pready = 1'b1;
   assign o_prdata = prdata_r;
   assign o_pslverr = slverr_r;
   assign o_irq = irq_r;
   assign o_trig_out = tro_r;
endmodule : mdc_copy_channel

// [core/mdc_pair_buffer.sv]
`timescale 1ns/1ns
// ************************************************************
// small element buffer between read and write side
// ************************************************************
module mdc_pair_buffer #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W:0] FULL_CNT = (PTR_W + 1)'(DEPTH);

   logic [WIDTH-1:0] entry_r [DEPTH]; // storage words
   logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt; // next slot to fill
   logic [PTR_W-1:0] rd_ptr_r, rd_ptr_nxt; // oldest slot
   logic [PTR_W:0] cnt_r, cnt_nxt; // words held
   logic push; // word accepted
   logic pop; // word handed on

   // honest full and empty
   assign o_in_ready = (cnt_r != FULL_CNT);
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data = entry_r[rd_ptr_r];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   // pointer and level update
   always_comb begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      cnt_nxt = cnt_r;
      if (push) begin
         wr_ptr_nxt = (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
         rd_ptr_nxt = (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // one storage word per entry
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_entry
         logic [WIDTH-1:0] word_nxt;
         always_comb begin
            word_nxt = entry_r[gi];
            if (push && (wr_ptr_r == PTR_W'(gi))) begin
               word_nxt = i_in_data;
            end
         end
         always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               entry_r[gi] <= '0;
            end else begin
               entry_r[gi] <= word_nxt;
            end
         end
      end
   endgenerate
endmodule : mdc_pair_buffer

// [core/mdc_pkg.sv]
// ************************************************************
// memory copy channel constants
// ************************************************************
package mdc_pkg;
   // apb register offsets, byte addresses
   localparam logic [7:0] MDC_OFS_CTRL = 8'h00;
   localparam logic [7:0] MDC_OFS_CH_CTL = 8'h04;
   localparam logic [7:0] MDC_OFS_CURR_PTR = 8'h08;
   localparam logic [7:0] MDC_OFS_SW_TRIG = 8'h0c;
   localparam logic [7:0] MDC_OFS_STATUS = 8'h10;
   localparam logic [7:0] MDC_OFS_SRC = 8'h14;
   localparam logic [7:0] MDC_OFS_DST = 8'h18;
   // register bit positions
   localparam int MDC_CTRL_EN_BIT = 0;
   localparam int MDC_CH_EN_BIT = 0;
   localparam int MDC_CH_PRIO_LSB = 4;
   localparam int MDC_SWT_BIT = 0;
   localparam int MDC_ST_BUSY_BIT = 0;
   localparam int MDC_ST_DONE_BIT = 1;
   localparam int MDC_ST_ERR_BIT = 2;
   localparam int MDC_ST_STATE_LSB = 4;
   // descriptor control word fields
   localparam int MDC_DC_WAIT_BIT = 0;
   localparam int MDC_DC_IRQ_LSB = 1;
   localparam int MDC_DC_TRO_LSB = 3;
   localparam int MDC_DC_STOP_BIT = 5;
   localparam int MDC_DC_SIZE_LSB = 6;
   localparam int MDC_DC_TYPE_LSB = 8;
   // loop control word fields
   localparam int MDC_LC_X_LSB = 0;
   localparam int MDC_LC_Y_LSB = 16;
   // descriptor operation types
   localparam logic [2:0] MDC_TYPE_SINGLE = 3'h0;
   localparam logic [2:0] MDC_TYPE_ONE_D = 3'h1;
   localparam logic [2:0] MDC_TYPE_TWO_D = 3'h2;
   localparam logic [2:0] MDC_TYPE_MEMCPY = 3'h3;
   localparam logic [2:0] MDC_TYPE_SCATTER = 3'h4;
   localparam logic [2:0] MDC_TYPE_CRC = 3'h5;
   // interrupt and output trigger select codes
   localparam logic [1:0] MDC_EV_ELEM = 2'h0;
   localparam logic [1:0] MDC_EV_XLOOP = 2'h1;
   localparam logic [1:0] MDC_EV_DESCR = 2'h2;
   localparam logic [1:0] MDC_EV_CHAIN = 2'h3;
   // element size codes
   localparam logic [1:0] MDC_SIZE_8 = 2'h0;
   localparam logic [1:0] MDC_SIZE_16 = 2'h1;
   localparam logic [1:0] MDC_SIZE_32 = 2'h2;
   // descriptor word indices
   localparam logic [2:0] MDC_DW_CTL = 3'h0;
   localparam logic [2:0] MDC_DW_SRC = 3'h1;
   localparam logic [2:0] MDC_DW_DST = 3'h2;
   localparam logic [2:0] MDC_DW_LOOP = 3'h3;
   localparam logic [2:0] MDC_DW_NEXT = 3'h4;
   // address steps and null link
   localparam logic [31:0] MDC_WORD_BYTES = 32'h4;
   localparam logic [31:0] MDC_PAIR_BYTES = 32'h8;
   localparam logic [31:0] MDC_ONE = 32'h1;
   localparam logic [31:0] MDC_NULL_PTR = 32'h0;
   // channel sequencer states
   typedef enum logic [2:0] {
      MDC_IDLE,
      MDC_FETCH,
      MDC_SCAT_ADDR,
      MDC_READ,
      MDC_WRITE,
      MDC_FINISH,
      MDC_WAIT_REL
   } mdc_state_t;
endpackage : mdc_pkg

// [testbench/mdc_copy_channel_properties.sv]
`timescale 1ns/1ns
// ************************************************************
// port checker for the copy channel
// ************************************************************
module mdc_copy_channel_properties (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // watched ports
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_mem_req,
   input wire logic o_mem_we,
   input wire logic [31:0] o_mem_addr,
   input wire logic [1:0] o_mem_size,
   input wire logic [31:0] o_mem_wdata,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata,
   input wire logic o_irq,
   input wire logic o_trig_out
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   // last word read, so a word write can be tied to it
   logic [31:0] last_rd_r;
   logic [31:0] last_rd_nxt;
   always_comb begin
      last_rd_nxt = (o_mem_req && !o_mem_we && i_mem_ack) ? i_mem_rdata : last_rd_r;
   end
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         last_rd_r <= '0;
      end else begin
         last_rd_r <= last_rd_nxt;
      end
   end
   a_req_held: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr)
      && $stable(o_mem_we) && $stable(o_mem_size)) else $error("memory request moved before ack");
   a_write_then_read: assert property (o_mem_req && o_mem_we && i_mem_ack |=> !o_mem_we)
      else $error("write not followed by read or idle");
   a_word_copied: assert property (o_mem_req && o_mem_we && o_mem_size == 2'h2
      |-> o_mem_wdata == last_rd_r) else $error("written word differs from word read");
   a_irq_pulse: assert property (o_irq |=> !o_irq) else $error("irq longer than one cycle");
   a_trig_pulse: assert property (o_trig_out |=> !o_trig_out) else $error("trigger out too long");
   a_event_cause: assert property (o_irq || o_trig_out |-> $past(i_mem_ack) || $past(i_mem_ack, 2))
      else $error("event without a completed beat");
   a_ready_always: assert property (o_pready) else $error("apb ready low");
   a_err_no_data: assert property (o_pslverr |-> o_prdata == 32'h0) else $error("error read carries data");
   c_irq: cover property (o_irq);
   c_write_beat: cover property (o_mem_req && o_mem_we && i_mem_ack);
   c_slverr: cover property (o_pslverr);
endmodule : mdc_copy_channel_properties
bind mdc_copy_channel mdc_copy_channel_properties i_props (.i_ref_clk, .i_arst_n, .o_prdata, .o_pready,
   .o_pslverr, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_size, .o_mem_wdata, .i_mem_ack, .i_mem_rdata,
   .o_irq, .o_trig_out);

// [testbench/mdc_mem_model.sv]
`timescale 1ns/1ns
// ************************************************************
// system memory on the channel's master port
// ************************************************************
module mdc_mem_model (
   input wire logic i_ref_clk,
   input wire logic i_slow,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [31:0] i_addr,
   input wire logic [1:0] i_size,
   input wire logic [31:0] i_wdata,
   output logic o_ack,
   output logic [31:0] o_rdata
);
   logic [31:0] mem [0:255]; // word store, 1 kbyte
   int wait_c = 0; // stall counter
   int acc = 0; // completed beats
   int n;
   int off;
   initial o_ack = 1'b0;
   initial o_rdata = 32'h0;
   // one beat at a time; data bus toggles when not answering
   always @(posedge i_ref_clk) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) begin
         if (wait_c < (i_slow ? 2 : 0)) begin
            wait_c <= wait_c + 1;
         end else begin
            wait_c <= 0;
            o_ack <= 1'b1;
            acc <= acc + 1;
            off = i_addr[1:0];
            n = (i_size == 2'h0) ? 1 : (i_size == 2'h1) ? 2 : 4;
            o_rdata <= mem[i_addr[9:2]] >> (8 * off);
            // narrow elements land on their byte lanes
            if (i_we) for (int b = 0; b < 4; b++) if (b >= off && b < off + n)
               mem[i_addr[9:2]][8*b+:8] <= i_wdata[8*(b-off)+:8];
         end
      end
   end
endmodule : mdc_mem_model

// [testbench/test_memory_dma_copy_channel.sv]
`timescale 1ns/1ns
module test_memory_dma_copy_channel;
   import mdc_pkg::*;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, trig = 0, slow = 0;
   logic [7:0] pa = 8'h0;
   logic [31:0] pwd = 32'h0, prd, r;
   logic rdy, err, e, req, we, ack, irq, tro;
   logic [31:0] ma, mwd, mrd;
   logic [1:0] msz;
   int fail_count = 0, compares = 0, cyc = 0, irqs = 0, tros = 0;
   mdc_copy_channel i_dut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .i_trig_in(trig),
      .o_mem_req(req), .o_mem_we(we), .o_mem_addr(ma), .o_mem_size(msz), .o_mem_wdata(mwd), .i_mem_ack(ack),
      .i_mem_rdata(mrd), .o_irq(irq), .o_trig_out(tro)); // trigger out counted, routed nowhere
   mdc_mem_model i_mem (.i_ref_clk(clk), .i_slow(slow), .i_req(req), .i_we(we), .i_addr(ma), .i_size(msz),
      .i_wdata(mwd), .o_ack(ack), .o_rdata(mrd));
   initial forever #5 clk = ~clk;
   // ************************************************************
   // apb master and checks
   // ************************************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      r = prd; e = err;
      psel <= 1'b0; pen <= 1'b0;
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
   endtask : rd
   // poll until the channel is no longer busy
   task automatic wait_idle();
      repeat (4) @(posedge clk);
      for (int i = 0; i < 300; i++) begin
         apb(1'b0, MDC_OFS_STATUS, 32'h0);
         if (r[MDC_ST_BUSY_BIT] === 1'b0) break;
      end
   endtask : wait_idle
   task automatic final_report();
      if (fail_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : final_report
   always @(posedge clk) begin
      cyc++;
      if (irq === 1'b1) irqs++;
      if (tro === 1'b1) tros++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      for (int i = 0; i < 256; i++) i_mem.mem[i] = 32'h0;
      // word copy of three, chained to a byte copy of two
      i_mem.mem[8'h40] = 32'h382; i_mem.mem[8'h41] = 32'h200; i_mem.mem[8'h42] = 32'h280;
      i_mem.mem[8'h43] = 32'h2; i_mem.mem[8'h44] = 32'h140;
      i_mem.mem[8'h50] = 32'h304; i_mem.mem[8'h51] = 32'h2c0; i_mem.mem[8'h52] = 32'h2e1;
      i_mem.mem[8'h53] = 32'h1;
      i_mem.mem[8'h60] = 32'h40; i_mem.mem[8'h61] = 32'h2c0; i_mem.mem[8'h62] = 32'h2f0;
      for (int i = 0; i < 4; i++) i_mem.mem[8'h80 + i] = 32'h11223344 + i;
      i_mem.mem[8'hb0] = 32'ha1b2c3d4;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(MDC_OFS_CTRL, 32'h0);
      apb(1'b0, 8'h1c, 32'h0);
      chk(e, 1'b1);
      apb(1'b1, MDC_OFS_CTRL, 32'h0);
      apb(1'b1, MDC_OFS_CURR_PTR, 32'h100);
      apb(1'b1, MDC_OFS_CH_CTL, 32'h1);
      apb(1'b1, MDC_OFS_SW_TRIG, 32'h1);
      repeat (8) @(posedge clk);
      chk(i_mem.acc, 0);
      slow <= 1'b1;
      apb(1'b1, MDC_OFS_CTRL, 32'h1);
      apb(1'b1, MDC_OFS_SW_TRIG, 32'h1);
      wait_idle();
      for (int i = 0; i < 4; i++) chk(i_mem.mem[8'ha0 + i], i < 3 ? 32'h11223344 + i : 32'h0);
      chk(i_mem.mem[8'hb8], 32'h00c3d400);
      chk(irqs, 2);
      chk(tros, 5);
      rd(MDC_OFS_SRC, 32'h2c2);
      rd(MDC_OFS_CURR_PTR, 32'h0);
      rd(MDC_OFS_STATUS, 32'h2);
      apb(1'b1, MDC_OFS_STATUS, 32'h2);
      rd(MDC_OFS_STATUS, 32'h0);
      // single halfword started by the multiplexer line
      apb(1'b1, MDC_OFS_CURR_PTR, 32'h180);
      apb(1'b1, MDC_OFS_CH_CTL, 32'h1);
      slow <= 1'b0;
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      wait_idle();
      chk(i_mem.mem[8'hbc], 32'h0000c3d4);
      chk(irqs, 3);
      chk(tros, 6);
      final_report();
   end
endmodule : test_memory_dma_copy_channel
